// *** verilog/swr_pkg.sv ***
// swr_pkg: shared constants and types for the sleep/wake/id link
// assumes a 200 MHz core clock on both ends
package swr_pkg;

  // instruction bytes and id defaults (id read opcodes and id values arbitrary)
  localparam logic [7:0] OP_SLEEP     = 8'hB9;
  localparam logic [7:0] OP_WAKE      = 8'hAB;
  localparam logic [7:0] OP_JEDEC_DEF = 8'h31;
  localparam logic [7:0] OP_MAKER_DEF = 8'h32;
  localparam logic [7:0] MAKER_ID_DEF = 8'h5A;
  localparam logic [7:0] TYPE_ID_DEF  = 8'h3C;
  localparam logic [7:0] CAP_ID_DEF   = 8'h2D;
  localparam logic [7:0] DEV_ID_DEF   = 8'h1E;
  localparam logic [7:0] SIG_ID_DEF   = 8'h2B;

  // bit counter positions within a frame
  localparam logic [5:0] CNT_FIRST      = 6'h00;
  localparam logic [5:0] CNT_INSTR_LAST = 6'h07;
  localparam logic [5:0] CNT_ADDR_LAST  = 6'h1F;
  localparam logic [5:0] CNT_SIG_LAST   = 6'h27;
  localparam logic [5:0] CNT_MAX        = 6'h3F;
  localparam logic [5:0] INSTR_BITS     = 6'h08;
  localparam logic [5:0] HDR_BITS       = 6'h20;

  // timing in ns, converted to cycles at the core rate; host half clock given in cycles
  localparam int CLK_MHZ        = 200;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_SHORT_NS  = 3000;
  localparam int WAKE_LONG_NS   = 6000;
  localparam int SLEEP_CYC      = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_SHORT_CYC = WAKE_SHORT_NS * CLK_MHZ / 1000;
  localparam int WAKE_LONG_CYC  = WAKE_LONG_NS * CLK_MHZ / 1000;
  localparam int HOST_GAP_CYC   = (WAKE_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int HOST_HALF_CYC  = 4;

  // link-side decode mode
  typedef enum logic [2:0] {
    MODE_IDLE   = 3'b000,
    MODE_SLEEP  = 3'b001,
    MODE_JEDEC  = 3'b010,
    MODE_MADDR  = 3'b011,
    MODE_MOUT   = 3'b100,
    MODE_WDUMMY = 3'b101,
    MODE_WOUT   = 3'b110,
    MODE_IGNORE = 3'b111
  } swr_mode_e;

  // core-side power state
  typedef enum logic [1:0] {
    PWR_STANDBY  = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_ASLEEP   = 2'b10,
    PWR_WAKING   = 2'b11
  } swr_pwr_e;

  // host command selection
  typedef enum logic [1:0] {
    HOP_SLEEP = 2'b00,
    HOP_WAKE  = 2'b01,
    HOP_JEDEC = 2'b10,
    HOP_MAKER = 2'b11
  } swr_op_e;

  // host sequencer state
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_RUN  = 2'b01,
    HST_GAP  = 2'b10
  } swr_hst_e;

endpackage : swr_pkg

// *** verilog/swr_link_if.sv ***
// swr_link_if: serial select/clock/data wires between host and device
// assumes the bench instantiates it and connects both modports
`timescale 1ns/100ps
interface swr_link_if;
  logic cs_n;      // select, active low
  logic sclk;      // serial clock, idles low
  logic mosi;      // host to device data
  logic miso;      // device data out
  logic miso_oe;   // device drives data out
  logic miso_line;

  // resolved data-out wire, low when undriven
  assign miso_line = miso_oe & miso;

  modport dev  (input cs_n, sclk, mosi, output miso, miso_oe);
  modport host (output cs_n, sclk, mosi, input miso_line);
endinterface : swr_link_if

// *** verilog/swr_dev.sv ***
// swr_dev: device end of the sleep/wake/id command decoder
// assumes sclk from the host, busy levels on clk_i from the array logic
// Operation
// - asleep: only wake command decoded
// - standby needs no cycle; sleep only by command
// - host releases select after eighth sleep bit
// - host holds select low whole sequence
// - enter deep sleep after entry delay
// - sleep rejected during erase/program/status write
// - reset always comes up in standby
// - three-byte id shifted out on falling
// - select rise ends three-byte id read
// - three-byte id ignored during erase/program
// - maker read: instruction, two dummies, address
// - address bit zero picks id byte order
// - maker read ignored during erase/program
// - select rise ends maker read
// - wake: three dummies then signature out
// - signature repeats while select stays low
// - wake gives signature when not asleep
// - wake ignored during erase/program/status write unless asleep
// - full signature read: long wake delay
// - partial wake frame: short wake delay
// - wake command byte is ABh
// - sleep command byte is B9h
`timescale 1ns/100ps
module swr_dev
  import swr_pkg::*;
#(
  parameter logic [7:0] OP_JEDEC  = swr_pkg::OP_JEDEC_DEF,
  parameter logic [7:0] OP_MAKER  = swr_pkg::OP_MAKER_DEF,
  parameter logic [7:0] MAKER_ID  = swr_pkg::MAKER_ID_DEF,
  parameter logic [7:0] TYPE_ID   = swr_pkg::TYPE_ID_DEF,
  parameter logic [7:0] CAP_ID    = swr_pkg::CAP_ID_DEF,
  parameter logic [7:0] DEV_ID    = swr_pkg::DEV_ID_DEF,
  parameter logic [7:0] SIG_ID    = swr_pkg::SIG_ID_DEF,
  parameter int         SLEEP_DLY = swr_pkg::SLEEP_CYC,
  parameter int         WAKE_S    = swr_pkg::WAKE_SHORT_CYC,
  parameter int         WAKE_L    = swr_pkg::WAKE_LONG_CYC
) (
  // core clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // serial link
  swr_link_if.dev   link,
  // internal cycle indications
  input  wire logic erase_prog_busy_i,
  input  wire logic status_write_busy_i,
  // power state
  output logic      deep_sleep_o,
  output logic      standby_o
);
  import swr_pkg::*;

  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  logic             link_rst_n;
  logic [5:0]       cnt_reg;
  swr_mode_e        mode_reg, mode_next;
  logic [6:0]       in_reg;
  logic [23:0]      out_reg, out_next;
  logic [3:0]       lsync1_reg, lsync2_reg;
  logic [3:0]       status_reg;  // core-side busy/power levels, read by lsync1_reg
  logic             tgl_reg, sleep_ok_reg, wake_ok_reg, sig_full_reg;
  logic             so_reg, so_oe_reg;
  logic [7:0]       in_byte;
  logic             l_asleep, l_blocked, l_ep, l_any;
  logic             at_instr, at_addr, out_mode;

  // select high clears the frame logic
  assign link_rst_n = rst_n_i & ~link.cs_n;
  assign in_byte    = {in_reg, link.mosi};
  assign l_asleep   = lsync2_reg[0];
  assign l_blocked  = lsync2_reg[1];
  assign l_ep       = lsync2_reg[2];
  assign l_any      = lsync2_reg[2] | lsync2_reg[3];
  assign at_instr   = (mode_reg == MODE_IDLE) && (cnt_reg == CNT_INSTR_LAST);
  assign at_addr    = (cnt_reg == CNT_ADDR_LAST);
  assign out_mode   = (mode_reg == MODE_JEDEC) || (mode_reg == MODE_MOUT) ||
                      (mode_reg == MODE_WOUT);

  // instruction decode and output shifting
  always_comb begin
    mode_next = mode_reg;
    out_next  = out_reg;
    if (at_instr) begin
      mode_next = MODE_IGNORE;
      if (l_blocked) begin
        mode_next = MODE_IGNORE;
      end else if (l_asleep) begin
        if (in_byte == OP_WAKE) mode_next = MODE_WDUMMY;
      end else if (in_byte == OP_SLEEP) begin
        if (!l_any) mode_next = MODE_SLEEP;
      end else if (in_byte == OP_WAKE) begin
        if (!l_any) mode_next = MODE_WDUMMY;
      end else if (in_byte == OP_JEDEC) begin
        if (!l_ep) begin
          mode_next = MODE_JEDEC;
          out_next  = {MAKER_ID, TYPE_ID, CAP_ID};
        end
      end else if (in_byte == OP_MAKER) begin
        if (!l_ep) mode_next = MODE_MADDR;
      end
    end else begin
      case (mode_reg)
        MODE_SLEEP:  mode_next = MODE_IGNORE;
        MODE_MADDR: begin
          if (at_addr) begin
            mode_next = MODE_MOUT;
            out_next  = in_byte[0] ? {DEV_ID, MAKER_ID, 8'h00}
                                   : {MAKER_ID, DEV_ID, 8'h00};
          end
        end
        MODE_WDUMMY: begin
          if (at_addr) begin
            mode_next = MODE_WOUT;
            out_next  = {SIG_ID, 16'h0000};
          end
        end
        MODE_JEDEC:  out_next = {out_reg[22:0], 1'b0};
        MODE_MOUT:   out_next = {out_reg[22:8], out_reg[23], 8'h00};
        MODE_WOUT:   out_next = {out_reg[22:16], out_reg[23], 16'h0000};
        default:     mode_next = mode_reg;
      endcase
    end
  end

  // frame counter, mode and shifters
  always_ff @(posedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_reg  <= CNT_FIRST;
      mode_reg <= MODE_IDLE;
      in_reg   <= 7'h00;
      out_reg  <= 24'h00_0000;
    end else begin
      cnt_reg  <= (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 6'h01;
      mode_reg <= mode_next;
      in_reg   <= in_byte[6:0];
      out_reg  <= out_next;
    end
  end

  // frame results, held across select high for the core side
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_reg      <= 1'b0;
      sleep_ok_reg <= 1'b0;
      wake_ok_reg  <= 1'b0;
      sig_full_reg <= 1'b0;
      lsync1_reg   <= 4'h0;
      lsync2_reg   <= 4'h0;
    end else begin
      lsync1_reg   <= status_reg;
      lsync2_reg   <= lsync1_reg;
      if (cnt_reg == CNT_FIRST) tgl_reg <= ~tgl_reg;
      sleep_ok_reg <= at_instr && (mode_next == MODE_SLEEP);
      if (cnt_reg == CNT_FIRST) begin
        wake_ok_reg  <= 1'b0;
        sig_full_reg <= 1'b0;
      end else begin
        if (at_instr && (mode_next == MODE_WDUMMY)) wake_ok_reg <= 1'b1;
        if ((mode_reg == MODE_WOUT) && (cnt_reg == CNT_SIG_LAST))
          sig_full_reg <= 1'b1;
      end
    end
  end

  // data out changes on the falling edge; select high stops it
  always_ff @(negedge link.sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_reg    <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg    <= out_mode & out_reg[23];
      so_oe_reg <= out_mode;
    end
  end

  assign link.miso    = so_reg;
  assign link.miso_oe = so_oe_reg;

  // ------------------------------------------------------------
  // core domain
  // ------------------------------------------------------------
  logic [4:0]  csync1_reg, csync2_reg;
  logic        cs_prev_reg, seen_tgl_reg;
  swr_pwr_e    pwr_reg, pwr_next;
  logic [15:0] dly_reg, dly_next;
  logic        cs_rise, new_frame, busy_any;

  assign cs_rise   = csync2_reg[0] & ~cs_prev_reg;
  assign new_frame = cs_rise & (csync2_reg[4] != seen_tgl_reg);
  assign busy_any  = erase_prog_busy_i | status_write_busy_i;

  // power state sequencing: select rise starts sleep entry or wake, the delay count ends it
  always_comb begin
    pwr_next = pwr_reg;
    dly_next = (dly_reg == 16'h0000) ? 16'h0000 : dly_reg - 16'h0001;
    case (pwr_reg)
      PWR_STANDBY: begin
        if (new_frame && csync2_reg[3] && !busy_any) begin
          pwr_next = PWR_ENTERING;
          dly_next = 16'(SLEEP_DLY - 1);
        end
      end
      PWR_ENTERING: if (dly_reg == 16'h0000) pwr_next = PWR_ASLEEP;
      PWR_ASLEEP: begin
        if (new_frame && csync2_reg[2]) begin
          pwr_next = PWR_WAKING;
          dly_next = csync2_reg[1] ? 16'(WAKE_L - 1)
                                   : 16'(WAKE_S - 1);
        end
      end
      PWR_WAKING: if (dly_reg == 16'h0000) pwr_next = PWR_STANDBY;
      default: pwr_next = PWR_STANDBY;
    endcase
  end

  // synchronisers, state and registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      csync1_reg   <= 5'h01;
      csync2_reg   <= 5'h01;
      cs_prev_reg  <= 1'b1;
      seen_tgl_reg <= 1'b0;
      pwr_reg      <= PWR_STANDBY;
      dly_reg      <= 16'h0000;
      status_reg   <= 4'h0;
      deep_sleep_o <= 1'b0;
      standby_o    <= 1'b0;
    end else begin
      csync1_reg   <= {tgl_reg, sleep_ok_reg, wake_ok_reg, sig_full_reg, link.cs_n};
      csync2_reg   <= csync1_reg;
      cs_prev_reg  <= csync2_reg[0];
      if (cs_rise) seen_tgl_reg <= csync2_reg[4];
      pwr_reg      <= pwr_next;
      dly_reg      <= dly_next;
      status_reg   <= {status_write_busy_i, erase_prog_busy_i,
                       (pwr_next == PWR_ENTERING) || (pwr_next == PWR_WAKING),
                       pwr_next == PWR_ASLEEP};
      deep_sleep_o <= (pwr_next == PWR_ASLEEP);
      standby_o    <= (pwr_next == PWR_STANDBY) && csync2_reg[0] && !busy_any;
    end
  end

endmodule : swr_dev

// *** verilog/swr_host.sv ***
// swr_host: host end issuing sleep, wake and id read frames
// assumes clk_i is fast enough to divide down to the serial clock
`timescale 1ns/100ps
module swr_host
  import swr_pkg::*;
#(
  parameter logic [7:0] OP_JEDEC = swr_pkg::OP_JEDEC_DEF,
  parameter logic [7:0] OP_MAKER = swr_pkg::OP_MAKER_DEF,
  parameter int         HALF     = swr_pkg::HOST_HALF_CYC,
  parameter int         GAP      = swr_pkg::HOST_GAP_CYC
) (
  // core clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_n_i,
  // serial link
  swr_link_if.host     link,
  // command request
  input  wire logic    start_i,
  input  swr_pkg::swr_op_e op_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [3:0] rd_bytes_i,
  // answer
  output logic         ready_o,
  output logic [7:0]   rdata_o,
  output logic         rvalid_o,
  output logic         done_o
);
  import swr_pkg::*;

  swr_hst_e    st_reg;
  logic        cs_n_reg, sclk_reg, mosi_reg;
  logic [15:0] tim_reg;
  logic [7:0]  bit_reg, total_reg, hdr_reg;
  logic [31:0] tx_reg;
  logic [7:0]  rx_reg;
  logic [1:0]  msync_reg;
  logic [7:0]  rx_idx, bit_inc, n_bits, start_hdr;
  logic [31:0] start_tx;
  logic        sample_now, byte_end, tim_zero;

  // frame shape from the selected command
  assign n_bits    = {1'b0, rd_bytes_i, 3'b000};
  assign start_hdr = (op_i == HOP_WAKE || op_i == HOP_MAKER) ? {2'b00, HDR_BITS}
                                                              : {2'b00, INSTR_BITS};
  assign start_tx  = (op_i == HOP_SLEEP) ? {OP_SLEEP, 24'h00_0000} :
                     (op_i == HOP_WAKE)  ? {OP_WAKE, 24'h00_0000}  :
                     (op_i == HOP_JEDEC) ? {OP_JEDEC, 24'h00_0000} :
                                           {OP_MAKER, 16'h0000, addr_i};
  assign rx_idx     = bit_reg - hdr_reg;
  assign bit_inc    = bit_reg + 8'h01;
  assign tim_zero   = (tim_reg == 16'h0000);
  assign sample_now = (st_reg == HST_RUN) && tim_zero && !sclk_reg &&
                      (bit_reg >= hdr_reg);
  assign byte_end   = sample_now && (rx_idx[2:0] == 3'b111);

  // frame sequencer: mode 0, data set while clock low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg    <= HST_IDLE;
      cs_n_reg  <= 1'b1;
      sclk_reg  <= 1'b0;
      mosi_reg  <= 1'b0;
      tim_reg   <= 16'h0000;
      bit_reg   <= 8'h00;
      total_reg <= 8'h00;
      hdr_reg   <= 8'h00;
      tx_reg    <= 32'h0000_0000;
      rx_reg    <= 8'h00;
      msync_reg <= 2'b00;
      ready_o   <= 1'b0;
      rdata_o   <= 8'h00;
      rvalid_o  <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      msync_reg <= {msync_reg[0], link.miso_line};
      rvalid_o  <= byte_end;
      done_o    <= 1'b0;
      if (byte_end) rdata_o <= {rx_reg[6:0], msync_reg[1]};
      case (st_reg)
        HST_IDLE: begin
          ready_o <= 1'b1;
          if (start_i) begin
            st_reg    <= HST_RUN;
            ready_o   <= 1'b0;
            cs_n_reg  <= 1'b0;
            tx_reg    <= start_tx;
            mosi_reg  <= start_tx[31];
            bit_reg   <= 8'h00;
            hdr_reg   <= start_hdr;
            total_reg <= (op_i == HOP_SLEEP) ? {2'b00, INSTR_BITS} : start_hdr + n_bits;
            tim_reg   <= 16'(HALF - 1);
          end
        end
        HST_RUN: begin
          if (!tim_zero) begin
            tim_reg <= tim_reg - 16'h0001;
          end else if (!sclk_reg) begin
            sclk_reg <= 1'b1;
            tim_reg  <= 16'(HALF - 1);
            if (sample_now) rx_reg <= {rx_reg[6:0], msync_reg[1]};
          end else begin
            sclk_reg <= 1'b0;
            bit_reg  <= bit_inc;
            tim_reg  <= 16'(HALF - 1);
            if (bit_inc == total_reg) begin
              st_reg   <= HST_GAP;
              cs_n_reg <= 1'b1;
              mosi_reg <= 1'b0;
              tim_reg  <= 16'(GAP - 1);
            end else begin
              tx_reg   <= {tx_reg[30:0], 1'b0};
              mosi_reg <= tx_reg[30];
            end
          end
        end
        HST_GAP: begin
          if (!tim_zero) begin
            tim_reg <= tim_reg - 16'h0001;
          end else begin
            st_reg <= HST_IDLE;
            done_o <= 1'b1;
          end
        end
        default: st_reg <= HST_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = mosi_reg;

endmodule : swr_host

// *** tb/swr_link_asserts.sv ***
// swr_link_asserts: link-level checks between the host and device ends
// assumes the bench instantiates it beside the link with matching ids
`timescale 1ns/100ps
module swr_link_asserts
  import swr_pkg::*;
#(
  parameter logic [7:0] OP_JEDEC = swr_pkg::OP_JEDEC_DEF,
  parameter logic [7:0] OP_MAKER = swr_pkg::OP_MAKER_DEF,
  parameter logic [7:0] MAKER_ID = swr_pkg::MAKER_ID_DEF,
  parameter logic [7:0] TYPE_ID  = swr_pkg::TYPE_ID_DEF,
  parameter logic [7:0] CAP_ID   = swr_pkg::CAP_ID_DEF,
  parameter logic [7:0] DEV_ID   = swr_pkg::DEV_ID_DEF,
  parameter logic [7:0] SIG_ID   = swr_pkg::SIG_ID_DEF
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  logic [6:0]  rise_cnt;  // sclk rises so far in this frame
  logic [7:0]  instr;     // instruction byte of the frame
  logic        addr_lsb;  // last header bit of a maker read
  wire         frame_clr = cs_n | ~rst_n_i;
  wire         hdr_done  = rise_cnt >= 7'h08;
  wire         data_ph   = rise_cnt >= 7'h20;
  wire  [23:0] id_word   = {MAKER_ID, TYPE_ID, CAP_ID};
  wire  [15:0] id_pair   = addr_lsb ? {DEV_ID, MAKER_ID} : {MAKER_ID, DEV_ID};
  wire  [4:0]  jedec_idx = 5'h1F - rise_cnt[4:0];

  // count rises and capture instruction and address bit
  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rise_cnt <= 7'h00;
      instr    <= 8'h00;
      addr_lsb <= 1'b0;
    end else begin
      if (rise_cnt != 7'h7F) rise_cnt <= rise_cnt + 7'h01;
      if (!hdr_done) instr <= {instr[6:0], mosi};
      if (rise_cnt == 7'h1F) addr_lsb <= mosi;
    end
  end

  // ---------------------------------------------------------------
  // assertions and covers
  // ---------------------------------------------------------------
  AST_OE_OFF_DESELECT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n |-> !miso_oe) else $error("data out driven while deselected");
  AST_MISO_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!cs_n && sclk && $past(sclk)) |-> ($stable(miso) && $stable(miso_oe)))
    else $error("data out changed while serial clock high");
  AST_HEADER_QUIET: assert property (@(posedge sclk) disable iff (frame_clr)
    !hdr_done |-> !miso_oe) else $error("data out during instruction");
  AST_DUMMY_QUIET: assert property (@(posedge sclk) disable iff (frame_clr)
    (hdr_done && !data_ph && (instr == OP_WAKE || instr == OP_MAKER)) |-> !miso_oe)
    else $error("data out during dummy or address bytes");
  AST_JEDEC_DATA: assert property (@(posedge sclk) disable iff (frame_clr)
    (instr == OP_JEDEC && hdr_done && miso_oe) |-> (miso == (!data_ph && id_word[jedec_idx])))
    else $error("three-byte id bit wrong");
  AST_MAKER_ORDER: assert property (@(posedge sclk) disable iff (frame_clr)
    (instr == OP_MAKER && data_ph && miso_oe) |-> (miso == id_pair[4'hF - rise_cnt[3:0]]))
    else $error("maker read bit or order wrong");
  AST_SIG_REPEAT: assert property (@(posedge sclk) disable iff (frame_clr)
    (instr == OP_WAKE && data_ph && miso_oe) |-> (miso == SIG_ID[3'h7 - rise_cnt[2:0]]))
    else $error("signature bit wrong");
  AST_SLEEP_EIGHT: assert property (@(posedge sclk) disable iff (frame_clr)
    (rise_cnt == 7'h08) |-> (instr != OP_SLEEP)) else $error("ninth clock on sleep frame");
  AST_SCLK_IN_FRAME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sclk |-> !cs_n) else $error("serial clock high while deselected");
  AST_HOST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sclk && $past(sclk)) |-> ($stable(mosi) && $stable(cs_n)))
    else $error("host data or select moved while clock high");

  COV_SIG: cover property (@(posedge sclk) instr == OP_WAKE && data_ph && miso_oe);
  COV_JEDEC: cover property (@(posedge sclk) instr == OP_JEDEC && hdr_done && miso_oe);
  COV_SWAP: cover property (@(posedge sclk) instr == OP_MAKER && addr_lsb && miso_oe);
  COV_SLEEP: cover property (@(posedge sclk) rise_cnt == 7'h07 && instr[6:0] == OP_SLEEP[7:1]);
endmodule : swr_link_asserts

// *** tb/testbench.sv ***
// testbench: host and device ends joined by the link, random id traffic
// assumes package, link interface and both ends compiled first
`timescale 1ns/100ps
module testbench;
  import swr_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic        clk_i;
  logic        rst_n_i;
  logic        start_i;
  swr_op_e     op_i;
  logic [7:0]  addr_i;
  logic [3:0]  rd_bytes_i;
  logic        erase_prog_busy_i;
  logic        status_write_busy_i;
  logic        ready_o;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        done_o;
  logic        deep_sleep_o;
  logic        standby_o;
  int          bad_count;
  int          n_tests;
  logic [31:0] seed;
  logic [7:0]  got [$];

  swr_link_if link ();

  swr_dev #(.SLEEP_DLY(4), .WAKE_S(4), .WAKE_L(8)) swr_dev_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link.dev),
    .erase_prog_busy_i(erase_prog_busy_i), .status_write_busy_i(status_write_busy_i),
    .deep_sleep_o(deep_sleep_o), .standby_o(standby_o));

  swr_host #(.GAP(16)) swr_host_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link(link.host), .start_i(start_i), .op_i(op_i),
    .addr_i(addr_i), .rd_bytes_i(rd_bytes_i), .ready_o(ready_o), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .done_o(done_o));

  swr_link_asserts swr_link_asserts_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

  // core clock, 5 ns period
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // byte expected at position i of a read
  function automatic logic [7:0] exp_byte(input swr_op_e op, input logic [7:0] a, input int i);
    case (op)
      HOP_JEDEC: exp_byte = (i == 0) ? MAKER_ID_DEF : (i == 1) ? TYPE_ID_DEF :
                            (i == 2) ? CAP_ID_DEF : 8'h00;
      HOP_MAKER: exp_byte = (i[0] == a[0]) ? MAKER_ID_DEF : DEV_ID_DEF;
      HOP_WAKE:  exp_byte = SIG_ID_DEF;
      default:   exp_byte = 8'h00;
    endcase
  endfunction : exp_byte

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // one host command; refused frames read as zeros
  task automatic run(input swr_op_e op, input logic [7:0] a, input logic [3:0] n,
                     input logic refused);
    int k;
    got.delete();
    k = 0;
    while (ready_o !== 1'b1 && k < 5000) begin
      @(negedge clk_i);
      k++;
    end
    op_i = op;
    addr_i = a;
    rd_bytes_i = n;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    while (done_o !== 1'b1 && k < 10000) begin
      if (rvalid_o === 1'b1) got.push_back(rdata_o);
      @(negedge clk_i);
      k++;
    end
    if (k >= 10000) begin
      bad_count++;
      $display("BAD done_o expected 1 seen 0");
      finish_test();
    end else begin
      check("byte count", {4'h0, n}, 8'(got.size()));
      foreach (got[i]) check("read byte", refused ? 8'h00 : exp_byte(op, a, i), got[i]);
      @(negedge clk_i);
    end
  endtask : run

  task automatic power(input logic deep, input logic stby);
    check("deep_sleep_o", {7'h00, deep}, {7'h00, deep_sleep_o});
    check("standby_o", {7'h00, stby}, {7'h00, standby_o});
  endtask : power

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    op_i = HOP_SLEEP;
    addr_i = 8'h00;
    rd_bytes_i = 4'h0;
    erase_prog_busy_i = 1'b0;
    status_write_busy_i = 1'b0;
    bad_count = 0;
    n_tests = 0;
    seed = 32'h57ac;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    power(1'b0, 1'b1);
    for (int t = 0; t < 14; t++) begin
      seed = xs(seed);
      run((seed[1:0] == 2'b00) ? HOP_JEDEC : swr_op_e'(seed[1:0]), seed[15:8],
          {1'b0, seed[4:2]} + 4'h1, 1'b0);
    end
    run(HOP_MAKER, 8'h00, 4'h4, 1'b0);
    run(HOP_MAKER, 8'h01, 4'h4, 1'b0);
    run(HOP_JEDEC, 8'h00, 4'h5, 1'b0);
    run(HOP_SLEEP, 8'h00, 4'h0, 1'b0);
    power(1'b1, 1'b0);
    run(HOP_JEDEC, 8'h00, 4'h3, 1'b1);
    run(HOP_MAKER, 8'h01, 4'h2, 1'b1);
    power(1'b1, 1'b0);
    run(HOP_WAKE, 8'h00, 4'h0, 1'b0);
    power(1'b0, 1'b1);
    run(HOP_SLEEP, 8'h00, 4'h0, 1'b0);
    run(HOP_WAKE, 8'h00, 4'h3, 1'b0);
    power(1'b0, 1'b1);
    erase_prog_busy_i = 1'b1;
    repeat (4) @(negedge clk_i);
    power(1'b0, 1'b0);
    run(HOP_SLEEP, 8'h00, 4'h0, 1'b0);
    power(1'b0, 1'b0);
    run(HOP_JEDEC, 8'h00, 4'h3, 1'b1);
    run(HOP_MAKER, 8'h01, 4'h2, 1'b1);
    run(HOP_WAKE, 8'h00, 4'h1, 1'b1);
    erase_prog_busy_i = 1'b0;
    status_write_busy_i = 1'b1;
    run(HOP_SLEEP, 8'h00, 4'h0, 1'b0);
    run(HOP_WAKE, 8'h00, 4'h1, 1'b1);
    run(HOP_JEDEC, 8'h00, 4'h3, 1'b0);
    status_write_busy_i = 1'b0;
    repeat (4) @(negedge clk_i);
    power(1'b0, 1'b1);
    run(HOP_SLEEP, 8'h00, 4'h0, 1'b0);
    power(1'b1, 1'b0);
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    power(1'b0, 1'b0);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    power(1'b0, 1'b1);
    run(HOP_WAKE, 8'h00, 4'h2, 1'b0);
    finish_test();
  end
endmodule : testbench
